// file: hw/flash_status_pkg.sv
// Package of field positions, reset values and carrier types for the flash status logic.
package flash_status_pkg;

	// ======================================================
	// Status register field positions
	localparam int BUSY_BIT        = 0;
	localparam int WEL_BIT         = 1;
	localparam int LEVEL_LO_BIT    = 2;
	localparam int LEVEL_HI_BIT    = 3;
	localparam int AUTO_INC_BIT    = 6;
	localparam int LOCK_BIT        = 7;
	localparam int TOP_LOCK_BIT    = 2;
	localparam int BOTTOM_LOCK_BIT = 3;

	// ======================================================
	// Reset values
	localparam logic [1:0] LEVEL_RESET = 2'h3;
	localparam logic       LOCK_RESET  = 1'h0;
	localparam logic       SECT_RESET  = 1'h0;

	// ======================================================
	// Array geometry and protected ranges
	localparam int              ADDR_W     = 18;
	localparam logic [17:0]     ADDR_TOP   = 18'h3FFFF;
	localparam logic [17:0]     QUARTER_LO = 18'h30000;
	localparam logic [17:0]     HALF_LO    = 18'h20000;
	localparam logic [17:0]     FULL_LO    = 18'h00000;
	localparam logic [17:0]     SECTOR_SZ  = 18'h01000;

	// ======================================================
	// Operation kinds
	typedef enum logic [2:0] {
		OP_BYTE_PROG,
		OP_AUTO_INC,
		OP_SECTOR_ERASE,
		OP_BLOCK_ERASE,
		OP_CHIP_ERASE
	} op_kind_t;

	// Array write request: kind and inclusive target range.
	typedef struct packed {
		op_kind_t          kind;
		logic [17:0]       first;
		logic [17:0]       last;
	} array_req_t;

	// Status-write payload.
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] sector;
		logic       has_second;
	} status_wr_t;

endpackage

// file: hw/protect_range_check.sv
// Range checker that decides whether an array write request hits protected memory.
`timescale 1ns/1ps
module protect_range_check
(
	// Request
	input  wire flash_status_pkg::array_req_t req,
	// Protection state
	input  wire logic [1:0]                   level,
	input  wire logic                         top_lock,
	input  wire logic                         bottom_lock,
	// Result
	output logic                              blocked
);

	// ======================================================
	// Range decode
	logic [17:0] prot_lo;
	wire         level_none;
	wire         level_hit;
	wire         top_hit;
	wire         bottom_hit;
	wire         chip_refused;

	always_comb
	begin
		unique case (level)
			2'h1:    prot_lo = flash_status_pkg::QUARTER_LO;
			2'h2:    prot_lo = flash_status_pkg::HALF_LO;
			2'h3:    prot_lo = flash_status_pkg::FULL_LO;
			default: prot_lo = flash_status_pkg::FULL_LO;
		endcase
	end

	assign level_none   = (level == 2'h0);
	assign level_hit    = !level_none && (req.last >= prot_lo);
	assign top_hit      = top_lock && (req.last > flash_status_pkg::ADDR_TOP
		- flash_status_pkg::SECTOR_SZ);
	assign bottom_hit   = bottom_lock && (req.first < flash_status_pkg::SECTOR_SZ);
	assign chip_refused = (req.kind == flash_status_pkg::OP_CHIP_ERASE) && !level_none;
	assign blocked      = level_hit || top_hit || bottom_hit || chip_refused;

endmodule

// file: hw/flash_status_wp.sv
// Status registers and write-protection logic of a serial flash.
// What this block does
// - pin low, lock set: refuse status write
// - pin high: lock bit ignored; status write still needs latch, not busy
// - busy bit read-only, cleared at power-up
// - write latch bit; zero rejects program/erase
// - latch clears on disable and completions
// - auto-increment bit; starts in byte mode
// - level bits select protected array range
// - level changes only when pin high/unlocked
// - chip erase only with level zero
// - level bits power up as 11
// - locked: freeze lock, level, sector bits
// - lock bit read/write, powers up zero
// - top/bottom sector lock bits, power-up zero
// - reserved bits read as zero
// - locked sector in range blocks command
`timescale 1ns/1ps
module flash_status_wp
(
	// Clock and reset
	input  wire logic                         CLOCK,
	input  wire logic                         RST_N,
	// Write-protect pin
	input  wire logic                         WP_N,
	// Command strobes from the decoder
	input  wire logic                         WRITE_ENABLE_CMD,
	input  wire logic                         WRITE_DISABLE_CMD,
	input  wire logic                         STATUS_WRITE_CMD,
	input  wire flash_status_pkg::status_wr_t STATUS_WRITE_DATA,
	// Array write request and sequencer handshake
	input  wire logic                         ARRAY_REQ,
	input  wire flash_status_pkg::array_req_t ARRAY_REQ_INFO,
	input  wire logic                         OP_DONE,
	input  wire logic                         AUTO_INC_END,
	// Results
	output logic                              ARRAY_START,
	output logic                              ARRAY_REJECT,
	output logic                              STATUS_WRITE_REJECT,
	// Register read values
	output logic [7:0]                        FLASH_STATUS,
	output logic [7:0]                        SECTOR_LOCK_STATUS
);

	// ======================================================
	// State
	logic [2:0] wp_sync_q;
	logic       wp_level_q;
	logic       busy_q;
	logic       write_enable_latch_q;
	logic       auto_inc_q;
	logic [1:0] level_q;
	logic       protect_lock_bit_q;
	logic       top_sector_lock_q;
	logic       bottom_sector_lock_q;
	logic       array_start_q;
	logic       array_reject_q;
	logic       status_reject_q;
	logic [7:0] flash_status_q;
	logic [7:0] sector_lock_q;

	wire range_blocked;
	wire locked;
	wire status_write_ok;
	wire array_ok;
	wire latch_clear;
	wire latch_set;
	wire [7:0] flash_status_d;
	wire [7:0] sector_lock_d;

	// ======================================================
	// Pin synchroniser: a change counts when stages two and three agree
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			wp_sync_q  <= 3'h0;
			wp_level_q <= 1'h0;
		end
		else
		begin
			wp_sync_q <= {wp_sync_q[1:0], WP_N};
			if (wp_sync_q[1] == wp_sync_q[2])
				wp_level_q <= wp_sync_q[2];
		end
	end

	// ======================================================
	// Decisions
	protect_range_check u_range
	(
		.req         (ARRAY_REQ_INFO),
		.level       (level_q),
		.top_lock    (top_sector_lock_q),
		.bottom_lock (bottom_sector_lock_q),
		.blocked     (range_blocked)
	);

	assign locked          = !wp_level_q && protect_lock_bit_q;
	// Status write also needs the latch, as the host sets it first.
	assign status_write_ok = STATUS_WRITE_CMD && !locked && write_enable_latch_q
		&& !busy_q;
	assign array_ok        = ARRAY_REQ && write_enable_latch_q && !busy_q
		&& !range_blocked;
	assign latch_set       = WRITE_ENABLE_CMD && !busy_q;
	assign latch_clear     = WRITE_DISABLE_CMD || (busy_q && OP_DONE)
		|| (auto_inc_q && AUTO_INC_END) || status_write_ok;

	// ======================================================
	// Busy, latch and mode
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			busy_q               <= 1'h0;
			write_enable_latch_q <= 1'h0;
			auto_inc_q           <= 1'h0;
		end
		else
		begin
			if (array_ok)
				busy_q <= 1'h1;
			else if (OP_DONE)
				busy_q <= 1'h0;
			if (latch_clear)
				write_enable_latch_q <= 1'h0;
			else if (latch_set)
				write_enable_latch_q <= 1'h1;
			if (array_ok && ARRAY_REQ_INFO.kind == flash_status_pkg::OP_AUTO_INC)
				auto_inc_q <= 1'h1;
			else if (AUTO_INC_END)
				auto_inc_q <= 1'h0;
		end
	end

	// ======================================================
	// Protection bits
	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			level_q              <= flash_status_pkg::LEVEL_RESET;
			protect_lock_bit_q   <= flash_status_pkg::LOCK_RESET;
			top_sector_lock_q    <= flash_status_pkg::SECT_RESET;
			bottom_sector_lock_q <= flash_status_pkg::SECT_RESET;
		end
		else if (status_write_ok)
		begin
			level_q <= {STATUS_WRITE_DATA.status[flash_status_pkg::LEVEL_HI_BIT],
				STATUS_WRITE_DATA.status[flash_status_pkg::LEVEL_LO_BIT]};
			protect_lock_bit_q <= STATUS_WRITE_DATA.status[flash_status_pkg::LOCK_BIT];
			if (STATUS_WRITE_DATA.has_second)
			begin
				top_sector_lock_q    <= STATUS_WRITE_DATA.sector[flash_status_pkg::TOP_LOCK_BIT];
				bottom_sector_lock_q <=
					STATUS_WRITE_DATA.sector[flash_status_pkg::BOTTOM_LOCK_BIT];
			end
		end
	end

	// ======================================================
	// Read values and result strobes
	assign flash_status_d = {protect_lock_bit_q, auto_inc_q, 2'h0, level_q,
		write_enable_latch_q, busy_q};
	assign sector_lock_d  = {4'h0, bottom_sector_lock_q, top_sector_lock_q, 2'h0};

	always_ff @(posedge CLOCK)
	begin
		if (!RST_N)
		begin
			flash_status_q  <= {flash_status_pkg::LOCK_RESET, 3'h0,
				flash_status_pkg::LEVEL_RESET, 2'h0};
			sector_lock_q   <= 8'h00;
			array_start_q   <= 1'h0;
			array_reject_q  <= 1'h0;
			status_reject_q <= 1'h0;
		end
		else
		begin
			flash_status_q  <= flash_status_d;
			sector_lock_q   <= sector_lock_d;
			array_start_q   <= array_ok;
			array_reject_q  <= ARRAY_REQ && !array_ok;
			status_reject_q <= STATUS_WRITE_CMD && !status_write_ok;
		end
	end

	assign FLASH_STATUS        = flash_status_q;
	assign SECTOR_LOCK_STATUS  = sector_lock_q;
	assign ARRAY_START         = array_start_q;
	assign ARRAY_REJECT        = array_reject_q;
	assign STATUS_WRITE_REJECT = status_reject_q;

	// ======================================================
	// Assertions
	a_lock_refuses_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(STATUS_WRITE_CMD && !wp_level_q && protect_lock_bit_q) |=> STATUS_WRITE_REJECT)
		else $error("Locked status write was not refused.");
	a_pin_high_accepts: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(STATUS_WRITE_CMD && wp_level_q && write_enable_latch_q && !busy_q)
		|=> !STATUS_WRITE_REJECT)
		else $error("Status write refused with pin high.");
	a_busy_drops_done: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(busy_q && OP_DONE) |=> ##1 !FLASH_STATUS[0])
		else $error("Busy bit did not clear after completion.");
	a_latch_gates_array: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ARRAY_REQ && !write_enable_latch_q) |=> (ARRAY_REJECT && !ARRAY_START))
		else $error("Array write started without write latch.");
	a_latch_clears: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(WRITE_DISABLE_CMD || status_write_ok) |=> ##1 !FLASH_STATUS[1])
		else $error("Write latch not cleared.");
	a_chip_needs_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ARRAY_REQ && ARRAY_REQ_INFO.kind == flash_status_pkg::OP_CHIP_ERASE
		&& level_q != 2'h0) |=> !ARRAY_START)
		else $error("Chip erase started with protection set.");
	a_lock_freezes_bits: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(!wp_level_q && protect_lock_bit_q) |=> ($stable(level_q)
		&& $stable(protect_lock_bit_q) && $stable(top_sector_lock_q)
		&& $stable(bottom_sector_lock_q)))
		else $error("Locked protection bits changed.");
	a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(FLASH_STATUS[5:4] == 2'h0) && (SECTOR_LOCK_STATUS[7:4] == 4'h0)
		&& (SECTOR_LOCK_STATUS[1:0] == 2'h0))
		else $error("Reserved status bits not zero.");
	a_sector_blocks: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(ARRAY_REQ && bottom_sector_lock_q && ARRAY_REQ_INFO.first < 18'h01000)
		|=> ARRAY_REJECT)
		else $error("Locked bottom sector was written.");

endmodule

// file: bench/seq_model.sv
// Sequencer stand-in that finishes each accepted array operation after a set delay.
`timescale 1ns/1ps
module seq_model
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Handshake
	input  wire logic       start,
	input  wire logic [3:0] lat,
	output logic            done
);
	logic [3:0] cnt_q;

	always_ff @(posedge clock)
	begin
		done <= rst_n && cnt_q == 4'h1;
		if (!rst_n)
			cnt_q <= 4'h0;
		else if (start)
			cnt_q <= lat;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule

// file: bench/tb_top.sv
// Self-checking testbench for the flash status and write-protection block.
`timescale 1ns/1ps
module tb_top;
	logic                         clock;
	logic                         rst_n;
	logic                         wp_n;
	logic [3:0]                   strb;
	logic [3:0]                   lat;
	logic                         op_done;
	logic                         a_end;
	logic                         a_st;
	logic                         a_rj;
	logic                         s_rj;
	logic [7:0]                   fst;
	logic [7:0]                   sst;
	flash_status_pkg::status_wr_t swd;
	flash_status_pkg::array_req_t req;
	int                           err_total = 0;
	int                           samples_checked = 0;
	int                           cyc = 0;

	flash_status_wp i_flash_status_wp (.CLOCK(clock), .RST_N(rst_n), .WP_N(wp_n),
		.WRITE_ENABLE_CMD(strb[3]), .WRITE_DISABLE_CMD(strb[2]),
		.STATUS_WRITE_CMD(strb[1]), .STATUS_WRITE_DATA(swd), .ARRAY_REQ(strb[0]),
		.ARRAY_REQ_INFO(req), .OP_DONE(op_done), .AUTO_INC_END(a_end),
		.ARRAY_START(a_st), .ARRAY_REJECT(a_rj), .STATUS_WRITE_REJECT(s_rj),
		.FLASH_STATUS(fst), .SECTOR_LOCK_STATUS(sst));

	seq_model i_seq_model (.clock(clock), .rst_n(rst_n), .start(a_st), .lat(lat),
		.done(op_done));

	// ======================================================
	// Clock, timeout and checking helpers
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Pulses strobes for one cycle, checks the result pulses, waits for status.
	// The result pulses stand for one cycle only, so they are judged at the first falling edge.
	task automatic op(input logic [3:0] s, input logic [2:0] res);
		strb = s;
		@(negedge clock);
		strb = 4'h0;
		chk({5'h00, a_st, a_rj, s_rj}, {5'h00, res});
		@(negedge clock);
		@(negedge clock);
	endtask

	// ======================================================
	// Scenarios
	task automatic t_status();
		chk(fst, 8'h0C);
		chk(sst, 8'h00);
		op(4'h2, 3'h1);
		op(4'h8, 3'h0);
		chk(fst, 8'h0E);
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h00000, 18'h00000};
		op(4'h1, 3'h2);
		op(4'h8, 3'h0);
		swd = '{8'hFF, 8'hFF, 1'b1};
		op(4'h2, 3'h0);
		chk(fst, 8'h8C);
		chk(sst, 8'h0C);
	endtask

	task automatic t_lock();
		op(4'h8, 3'h0);
		swd = '{8'h00, 8'h00, 1'b1};
		op(4'h2, 3'h1);
		chk(fst, 8'h8E);
		chk(sst, 8'h0C);
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h00000, 18'h00000};
		op(4'h1, 3'h2);
		wp_n = 1'b1;
		repeat (5) @(negedge clock);
		swd = '{8'h04, 8'h04, 1'b1};
		op(4'h2, 3'h0);
		chk(fst, 8'h04);
		chk(sst, 8'h04);
	endtask

	task automatic t_array();
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h10000, 18'h10000};
		op(4'h1, 3'h2);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h30000, 18'h30000};
		op(4'h1, 3'h2);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_CHIP_ERASE, 18'h00000, 18'h3FFFF};
		op(4'h1, 3'h2);
		op(4'h8, 3'h0);
		swd = '{8'h00, 8'h04, 1'b1};
		op(4'h2, 3'h0);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h3F800, 18'h3F800};
		op(4'h1, 3'h2);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_BYTE_PROG, 18'h3EFFF, 18'h3EFFF};
		op(4'h1, 3'h4);
		chk(fst, 8'h03);
		repeat (12) @(negedge clock);
		chk(fst, 8'h00);
	endtask

	task automatic t_erase();
		lat = 4'h1;
		op(4'h8, 3'h0);
		swd = '{8'h00, 8'h00, 1'b1};
		op(4'h2, 3'h0);
		chk(sst, 8'h00);
		op(4'h8, 3'h0);
		op(4'h4, 3'h0);
		chk(fst, 8'h00);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_CHIP_ERASE, 18'h00000, 18'h3FFFF};
		op(4'h1, 3'h4);
		repeat (6) @(negedge clock);
		chk(fst, 8'h00);
		op(4'h8, 3'h0);
		req = '{flash_status_pkg::OP_AUTO_INC, 18'h00000, 18'h00001};
		op(4'h1, 3'h4);
		chk(fst & 8'h40, 8'h40);
		repeat (6) @(negedge clock);
		a_end = 1'b1;
		@(negedge clock);
		a_end = 1'b0;
		repeat (2) @(negedge clock);
		chk(fst, 8'h00);
	endtask

	initial
	begin
		rst_n = 1'b0;
		wp_n = 1'b0;
		strb = 4'h0;
		lat = 4'h8;
		a_end = 1'b0;
		swd = '0;
		req = '0;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		t_status();
		t_lock();
		t_array();
		t_erase();
		print_verdict();
	end
endmodule
